// >>> logic/cam_pkg.sv
// ----------------------------------------
// Register map and field layout
// ----------------------------------------
package cam_pkg;
    // Register offsets
    localparam logic [7:0] OFS_CONFIG_TWO = 8'h73;
    localparam logic [7:0] OFS_ALERT_MASK_ONE = 8'h74;
    localparam logic [7:0] OFS_ALERT_MASK_TWO = 8'h75;
    // Values after reset
    localparam logic [7:0] RST_CONFIG_TWO = 8'h00;
    localparam logic [7:0] RST_ALERT_MASK_ONE = 8'h00;
    localparam logic [7:0] RST_ALERT_MASK_TWO = 8'h00;
    localparam logic [7:0] RST_READ_DATA = 8'h00;
    // Answer to an unmapped read
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // Config two fields
    localparam int CFG_PRES_EN = 0;
    localparam int CFG_DET_LO = 1;
    localparam int CFG_DET_HI = 3;
    localparam int CFG_AVG_OFF = 4;
    localparam int CFG_ATTENUATOR_BYPASS_BYP = 5;
    localparam int CFG_SINGLE = 6;
    localparam int CFG_SHUTDOWN_REQUEST = 7;
    // Software writable bits of config two
    localparam logic [7:0] CFG_WR_MASK = 8'hF1;
    // Mask one fields
    localparam int M1_PROC_SUPPLY = 1;
    localparam int M1_SUPPLY = 2;
    localparam int M1_REMOTE_ONE = 4;
    localparam int M1_LOCAL = 5;
    localparam int M1_REMOTE_TWO = 6;
    localparam int M1_OVERRIDE = 7;
    // Mask two fields
    localparam int M2_OVERTEMP = 1;
    localparam int M2_FAN_ONE = 2;
    localparam int M2_FAN_THREE = 4;
    localparam int M2_FAN_FOUR = 5;
    localparam int M2_DIODE_ONE = 6;
    localparam int M2_DIODE_TWO = 7;
    // Bits of status one that the mask one gates
    localparam logic [7:0] M1_GATED = 8'h76;
    // Bits of status two that the mask two gates
    localparam logic [7:0] M2_GATED = 8'hFE;
    // Single channel source codes
    localparam logic [2:0] SRC_PROC_SUPPLY = 3'h1;
    localparam logic [2:0] SRC_SUPPLY = 3'h2;
    localparam logic [2:0] SRC_REMOTE_ONE = 3'h5;
    localparam logic [2:0] SRC_LOCAL = 3'h6;
    localparam logic [2:0] SRC_REMOTE_TWO = 3'h7;
    localparam logic [2:0] SRC_NONE = 3'h0;
    // Synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 2;
endpackage : cam_pkg

// >>> logic/cam_regs.sv
`timescale 1ns/1ps
module cam_regs #(
    parameter int DATA_W = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Register port from the serial interface
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata,
    // Lock from the first configuration register
    input wire logic config_lock,
    // Four-wire fan sense pins, channels 1 to 3
    input wire logic [2:0] four_wire_sense_pin,
    // Status events from the status registers
    input wire logic [DATA_W-1:0] status_one,
    input wire logic [DATA_W-1:0] status_two,
    // Fourth tach pin carries the overtemp input
    input wire logic fourth_tach_input_is_overtemp,
    input wire logic fan_four_fault,
    input wire logic overtemp_timer_event,
    // Fan drive polarity and source select field
    input wire logic polarity_invert,
    input wire logic [2:0] source_select,
    // Configuration controls to the datapath
    output logic averaging_disable,
    output logic attenuator_bypass,
    output logic single_channel_convert,
    output logic [2:0] convert_source,
    output logic convert_source_valid,
    // Fan drive override during shutdown
    output logic shutdown_request,
    output logic fan_force_off,
    output logic fan_off_level,
    // Alert pin, active low
    output logic smbalert_n
);

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------

    // Offset match is shared by the write and read paths,
    // so both always agree on which register a strobe hits
    // Address aimed at one offset, for writes and reads
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // Reserved codes must never steer the converter
    // Only five codes name a real input
    function automatic logic source_ok(input logic [2:0] c);
        case (c)
            cam_pkg::SRC_PROC_SUPPLY,
            cam_pkg::SRC_SUPPLY,
            cam_pkg::SRC_REMOTE_ONE,
            cam_pkg::SRC_LOCAL,
            cam_pkg::SRC_REMOTE_TWO: source_ok = 1'b1;
            default: source_ok = 1'b0;
        endcase
    endfunction : source_ok

    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------

    // Sense pins change with no regard to core_clk;
    // two stages trade two cycles of delay for safety
    // Detect bits therefore show a pin change two cycles late
    // Stage one is read only by stage two
    logic [2:0] sense_meta;
    logic [2:0] sense_sync;
    logic [2:0] next_sense_meta;
    logic [2:0] next_sense_sync;

    // Shift the sense pins through two stages
    always_comb begin
        next_sense_meta = four_wire_sense_pin;
        next_sense_sync = sense_meta;
    end

    // Register the synchroniser
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sense_meta <= 3'h0;
            sense_sync <= 3'h0;
        end else begin
            sense_meta <= next_sense_meta;
            sense_sync <= next_sense_sync;
        end
    end

    // ----------------------------------------
    // Register file
    // ----------------------------------------

    // Stored registers and their next values
    // Stored writable bits of config two
    logic [7:0] config_two;
    logic [7:0] alert_mask_one;
    logic [7:0] alert_mask_two;
    logic [7:0] next_config_two;
    logic [7:0] next_alert_mask_one;
    logic [7:0] next_alert_mask_two;
    // Detect bits as software sees them
    logic [2:0] detect_view;
    logic [7:0] config_view;

    // Lock from config one protects only config two;
    // the mask registers stay writable so alerts can be tuned
    // A write to any other offset changes nothing here
    // Write handling
    always_comb begin
        next_config_two = config_two;
        next_alert_mask_one = alert_mask_one;
        next_alert_mask_two = alert_mask_two;
        // Locked config ignores writes silently
        if (reg_wr && hit(reg_addr, cam_pkg::OFS_CONFIG_TWO) && !config_lock) begin
            // Detect bits are read-only, never stored
            next_config_two = reg_wdata[7:0] & cam_pkg::CFG_WR_MASK;
        end
        // Masks take the whole byte, no read-only bits
        if (reg_wr && hit(reg_addr, cam_pkg::OFS_ALERT_MASK_ONE)) begin
            next_alert_mask_one = reg_wdata[7:0];
        end
        // Bit zero of mask two is stored but gates nothing
        if (reg_wr && hit(reg_addr, cam_pkg::OFS_ALERT_MASK_TWO)) begin
            next_alert_mask_two = reg_wdata[7:0];
        end
    end

    // Register the register file
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            config_two <= cam_pkg::RST_CONFIG_TWO;
            alert_mask_one <= cam_pkg::RST_ALERT_MASK_ONE;
            alert_mask_two <= cam_pkg::RST_ALERT_MASK_TWO;
        end else begin
            config_two <= next_config_two;
            alert_mask_one <= next_alert_mask_one;
            alert_mask_two <= next_alert_mask_two;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------

    // Next read data; holds when no read is pending
    logic [DATA_W-1:0] next_reg_rdata;

    // Detect bits read zero while presence sensing is off
    always_comb begin
        detect_view = config_two[cam_pkg::CFG_PRES_EN] ? sense_sync : 3'h0;
        config_view = config_two;
        config_view[cam_pkg::CFG_DET_HI:cam_pkg::CFG_DET_LO] = detect_view;
    end

    // Registered read data gives the bus a fixed one-cycle answer
    // and keeps the mux glitches off the port
    // A write and a read in one cycle return the old value
    // Read data is held until the next read
    always_comb begin
        next_reg_rdata = reg_rdata;
        if (reg_rd) begin
            if (hit(reg_addr, cam_pkg::OFS_CONFIG_TWO)) begin
                next_reg_rdata = DATA_W'(config_view);
            end else if (hit(reg_addr, cam_pkg::OFS_ALERT_MASK_ONE)) begin
                next_reg_rdata = DATA_W'(alert_mask_one);
            end else if (hit(reg_addr, cam_pkg::OFS_ALERT_MASK_TWO)) begin
                next_reg_rdata = DATA_W'(alert_mask_two);
            end else begin
                // Unmapped offsets answer a fixed value
                next_reg_rdata = DATA_W'(cam_pkg::UNMAPPED_READ);
            end
        end
    end

    // Register the read data
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            reg_rdata <= DATA_W'(cam_pkg::RST_READ_DATA);
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    // ----------------------------------------
    // Alert gating
    // ----------------------------------------

    // Gating is pure logic on the live status inputs;
    // clearing a status bit is the status block's job
    // Alert is registered, so it lags an event by one cycle
    // Status two as gated, bit five chosen by pin use
    logic [7:0] status_two_eff;
    logic [7:0] gate_one;
    logic [7:0] gate_two;
    // Unmasked event sums per status register
    logic any_one;
    logic any_two;
    // Every mask two event bit set
    logic all_two_masked;
    // Alert level before the output flip-flop
    logic next_alert;

    // Mask bits only gate; status inputs pass through unaltered except status two bit five
    always_comb begin
        status_two_eff = status_two[7:0];
        // Same mask bit serves fan four or timer event
        status_two_eff[cam_pkg::M2_FAN_FOUR] = fourth_tach_input_is_overtemp ?
            overtemp_timer_event : fan_four_fault;
        // Ungated bits always pass; gated ones obey mask one
        gate_one = ~(alert_mask_one & cam_pkg::M1_GATED);
        // Mask two gates overtemp, fans and diodes
        gate_two = ~(alert_mask_two & cam_pkg::M2_GATED);
        // Override bit of mask one is not an event gate
        gate_one[cam_pkg::M1_OVERRIDE] = 1'b1;
        any_one = |(status_one[7:0] & gate_one);
        all_two_masked = &alert_mask_two[cam_pkg::M2_DIODE_TWO:cam_pkg::M2_OVERTEMP];
        any_two = |(status_two_eff & gate_two);
        // All masked yet override clear: events still alert
        // Bit zero is ungated, so it stays in the sum here too
        if (all_two_masked && !alert_mask_one[cam_pkg::M1_OVERRIDE]) begin
            any_two = |status_two_eff;
        end
        next_alert = any_one || any_two;
    end

    // ----------------------------------------
    // Control outputs
    // ----------------------------------------

    // Next values of the control outputs
    logic next_avg;
    logic next_attenuator_bypass;
    logic next_single;
    logic [2:0] next_source;
    logic next_source_valid;
    logic next_shutdown_request;
    logic next_off_level;

    // Mode and shutdown outputs mirror config two one cycle behind it, two cycles after a write
    // Shutdown and force-off come from one bit on purpose:
    // the fan drivers need not decode the register
    // Decode the stored configuration
    always_comb begin
        next_avg = config_two[cam_pkg::CFG_AVG_OFF];
        next_attenuator_bypass = config_two[cam_pkg::CFG_ATTENUATOR_BYPASS_BYP];
        next_single = config_two[cam_pkg::CFG_SINGLE];
        // Reserved codes are flagged, not forwarded
        next_source_valid = source_ok(source_select);
        next_source = next_source_valid ? source_select : cam_pkg::SRC_NONE;
        next_shutdown_request = config_two[cam_pkg::CFG_SHUTDOWN_REQUEST];
        // Off level is high only with inverted drive
        next_off_level = polarity_invert;
    end

    // Alert idles high, the released level of the pin
    // Reset values match config two at power-on
    // Every output leaves a flip-flop
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            averaging_disable <= 1'b0;
            attenuator_bypass <= 1'b0;
            single_channel_convert <= 1'b0;
            convert_source <= cam_pkg::SRC_NONE;
            convert_source_valid <= 1'b0;
            shutdown_request <= 1'b0;
            fan_force_off <= 1'b0;
            fan_off_level <= 1'b0;
            smbalert_n <= 1'b1;
        end else begin
            averaging_disable <= next_avg;
            attenuator_bypass <= next_attenuator_bypass;
            single_channel_convert <= next_single;
            convert_source <= next_source;
            convert_source_valid <= next_source_valid;
            shutdown_request <= next_shutdown_request;
            fan_force_off <= next_shutdown_request;
            fan_off_level <= next_off_level;
            smbalert_n <= !next_alert;
        end
    end

endmodule : cam_regs

// >>> dv/cam_regs_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port-level checker for the register bank
// ----------------------------------------
module cam_regs_assertions #(
    parameter int DATA_W = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // Events and fields
    input wire logic [DATA_W-1:0] status_one,
    input wire logic [DATA_W-1:0] status_two,
    input wire logic fan_four_fault,
    input wire logic overtemp_timer_event,
    input wire logic polarity_invert,
    input wire logic [2:0] source_select,
    // Outputs under watch
    input wire logic averaging_disable,
    input wire logic attenuator_bypass,
    input wire logic single_channel_convert,
    input wire logic [2:0] convert_source,
    input wire logic convert_source_valid,
    input wire logic shutdown_request,
    input wire logic fan_force_off,
    input wire logic fan_off_level,
    input wire logic smbalert_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Legal source codes; reserved ones must never reach the converter
    logic src_ok;
    assign src_ok = source_select inside {3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
    chk_force_off: assert property (reg_rd && reg_addr == 8'h73 |=>
        fan_force_off == reg_rdata[7])
        else $error("fan force off differs from stored shutdown bit");
    chk_off_level: assert property ($past(rstn) |-> fan_off_level == $past(polarity_invert))
        else $error("fan off level not taken from polarity");
    chk_src_valid: assert property ($past(rstn) |-> convert_source_valid == $past(src_ok))
        else $error("source valid flag wrong");
    chk_src_value: assert property ($past(rstn) |->
        convert_source == ($past(src_ok) ? $past(source_select) : 3'h0))
        else $error("convert source wrong");
    chk_reset_clear: assert property ($rose(rstn) |->
        !shutdown_request && !averaging_disable && reg_rdata == 8'h00)
        else $error("outputs not clear after reset");
    chk_cfg_mirror: assert property (reg_rd && reg_addr == 8'h73 |=>
        reg_rdata[7:4] == {shutdown_request, single_channel_convert, attenuator_bypass, averaging_disable})
        else $error("control outputs differ from config readback");
    chk_detect_gate: assert property (reg_rd && reg_addr == 8'h73 |=>
        reg_rdata[0] || reg_rdata[3:1] == 3'h0)
        else $error("detect bits shown while presence disabled");
    chk_ungated_alert: assert property ($past(rstn) &&
        (($past(status_one) & 8'h89) != 0 || $past(status_two[0]))
        |-> !smbalert_n) else $error("ungated event gave no alert");
    chk_quiet_alert: assert property ($past(rstn) && $past(status_one) == 0 && $past(status_two) == 0
        && !$past(fan_four_fault) && !$past(overtemp_timer_event) |-> smbalert_n) else $error("alert with no event");
    // Main scenarios reached
    cov_cfg_read: cover property (reg_rd && reg_addr == 8'h73);
    cov_alert: cover property (!smbalert_n);
    cov_shutdown: cover property (shutdown_request && convert_source_valid);
endmodule : cam_regs_assertions

bind cam_regs cam_regs_assertions #(.DATA_W(DATA_W)) u_chk (.core_clk(core_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .status_one(status_one),
    .status_two(status_two), .fan_four_fault(fan_four_fault), .overtemp_timer_event(overtemp_timer_event),
    .polarity_invert(polarity_invert), .source_select(source_select), .averaging_disable(averaging_disable),
    .attenuator_bypass(attenuator_bypass), .single_channel_convert(single_channel_convert),
    .convert_source(convert_source), .convert_source_valid(convert_source_valid),
    .shutdown_request(shutdown_request), .fan_force_off(fan_force_off), .fan_off_level(fan_off_level),
    .smbalert_n(smbalert_n));

// >>> dv/cam_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host side of the register port
// ----------------------------------------
module cam_host (
    // Clock
    input wire logic core_clk,
    // Requests toward the device
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata
);
    initial begin
        reg_addr = 8'hA5;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h5A;
    end
    // One byte per strobe; gap cycles model a slow host
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input int gap);
        repeat (gap + 1) @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        // Idle lines scrambled so a stale value never matches by luck
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : xfer
endmodule : cam_host

// >>> dv/config_and_alert_mask_regs_tb.sv
`timescale 1ns/1ps
module config_and_alert_mask_regs_tb;
    // ----------------------------------------
    // Stimulus and observation signals
    // ----------------------------------------
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, s1, s2, m1, m2, c, cfg;
    logic reg_wr, reg_rd, smbalert_n, ft, f4, ote, pol;
    logic config_lock = 1'b0, fourth_tach_input_is_overtemp = 1'b0, fan_four_fault = 1'b0;
    logic overtemp_timer_event = 1'b0, polarity_invert = 1'b0;
    logic [2:0] four_wire_sense_pin = 3'h0, source_select = 3'h0, src;
    logic [7:0] status_one = 8'h00, status_two = 8'h00;
    logic [7:0] exp_q[$];
    logic [1:0] rd_pipe = 2'b00;
    integer seed = 6;
    int errors = 0, num_checks = 0, cycles = 0;
    always #50 core_clk = ~core_clk;
    cam_host host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
    cam_regs dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .config_lock(config_lock),
        .four_wire_sense_pin(four_wire_sense_pin), .status_one(status_one), .status_two(status_two),
        .fourth_tach_input_is_overtemp(fourth_tach_input_is_overtemp), .fan_four_fault(fan_four_fault),
        .overtemp_timer_event(overtemp_timer_event), .polarity_invert(polarity_invert),
        .source_select(source_select), .averaging_disable(), .attenuator_bypass(), .single_channel_convert(),
        .convert_source(), .convert_source_valid(), .shutdown_request(), .fan_force_off(), .fan_off_level(),
        .smbalert_n(smbalert_n));
    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.xfer(1'b0, a, 8'h00, 0);
    endtask : rd
    // Expected alert level from events and masks
    function automatic logic want_alert(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] e2;
        e2 = status_two;
        e2[5] = fourth_tach_input_is_overtemp ? overtemp_timer_event : fan_four_fault;
        if (b[7:1] == 7'h7F && !a[7]) return (|(status_one & (~cam_pkg::M1_GATED | ~a))) || (|e2);
        return (|(status_one & (~cam_pkg::M1_GATED | ~a))) || e2[0] || (|(e2[7:1] & ~b[7:1]));
    endfunction : want_alert
    // Read answers are compared once settled, oldest note first
    always @(posedge core_clk) rd_pipe <= {rd_pipe[0], reg_rd};
    always @(negedge core_clk) begin
        if (rd_pipe[1]) begin
            check("reg_rdata", exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX, reg_rdata);
        end
    end
    task automatic final_report();
        if (errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            final_report();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        rd(cam_pkg::OFS_CONFIG_TWO, cam_pkg::RST_CONFIG_TWO);
        rd(cam_pkg::OFS_ALERT_MASK_ONE, cam_pkg::RST_ALERT_MASK_ONE);
        rd(cam_pkg::OFS_ALERT_MASK_TWO, cam_pkg::RST_ALERT_MASK_TWO);
        rd(8'h76, cam_pkg::UNMAPPED_READ);
        cfg = 8'h00;
        for (int i = 0; i < 40; i++) begin
            // New inputs are launched just after a rising edge
            @(posedge core_clk);
            {s1, s2, m1, m2} = $random(seed);
            {c, ft, f4, ote, pol, src} = 15'($random(seed));
            if (i % 4 == 0) m2 = m2 | 8'hFE;
            config_lock <= i[1];
            four_wire_sense_pin <= src;
            {status_one, status_two} <= {s1, s2};
            {fourth_tach_input_is_overtemp, fan_four_fault, overtemp_timer_event} <= {ft, f4, ote};
            {polarity_invert, source_select} <= {pol, src};
            host.xfer(1'b1, cam_pkg::OFS_CONFIG_TWO, c, i % 3);
            if (!i[1]) cfg = c & cam_pkg::CFG_WR_MASK;
            rd(cam_pkg::OFS_CONFIG_TWO, cfg | (cfg[0] ? {4'h0, src, 1'b0} : 8'h00));
            host.xfer(1'b1, cam_pkg::OFS_ALERT_MASK_ONE, m1, 0);
            host.xfer(1'b1, cam_pkg::OFS_ALERT_MASK_TWO, m2, 0);
            rd(cam_pkg::OFS_ALERT_MASK_ONE, m1);
            rd(cam_pkg::OFS_ALERT_MASK_TWO, m2);
            repeat (2) @(posedge core_clk);
            @(negedge core_clk);
            check("smbalert_n", {7'h00, !want_alert(m1, m2)}, {7'h00, smbalert_n});
        end
        repeat (3) @(posedge core_clk);
        final_report();
    end
endmodule : config_and_alert_mask_regs_tb
